// File: pbeu_pkg.sv
// Package for the pixel-bus endian unpacker: widths, depth codes, carriers.
// Assumes a single pixel load clock domain.
package pbeu_pkg;
    localparam int PBEU_BUS_W = 32;
    localparam int PBEU_FLD_W = 32;
    localparam int PBEU_CNT_W = 6;
    localparam logic pbeu_endian_rst = 1'b0;
    localparam logic pbeu_big_endian = 1'b1;

    typedef enum logic [2:0] {
        PBEU_D1 = 3'h0,
        PBEU_D2 = 3'h1,
        PBEU_D4 = 3'h2,
        PBEU_D8 = 3'h3,
        PBEU_D12 = 3'h4,
        PBEU_D16 = 3'h5,
        PBEU_D24 = 3'h6
    } pbeu_depth_t;

    typedef struct packed {
        logic [PBEU_BUS_W-1:0] data;
        logic valid;
    } pbeu_word_t;

    typedef struct packed {
        logic [PBEU_FLD_W-1:0] field;
        logic valid;
        logic last;
    } pbeu_pix_t;
endpackage

// File: pbeu_field_mirror.sv
// Mirrors the low bits of a field within a given width.
// Purely combinational; width is the active field width in bits.
`timescale 1ns/1ps
`default_nettype none
module pbeu_field_mirror (
    input wire logic [pbeu_pkg::PBEU_FLD_W-1:0] inField,
    input wire logic [pbeu_pkg::PBEU_CNT_W-1:0] width,
    output logic [pbeu_pkg::PBEU_FLD_W-1:0] outField
);
    import pbeu_pkg::*;
    always_comb begin
        outField = '0;
        for (int i = 0; i < PBEU_FLD_W; i++) begin
            if (i < int'(width)) begin
                outField[i] = inField[int'(width) - 1 - i];
            end
        end
    end
endmodule
`default_nettype wire

// File: pbeu_unpacker.sv
// Pixel-bus endian unpacker: splits 32-bit pixel-bus words into pixel fields.
// Assumes endian control and depth come from logic on the same pixel load clock.
// Notes on behaviour
// - Reset clears the latched endian select; each word then takes endianSel as it is loaded.
// - With endian select set, bits inside each pixel field are mirrored.
// - Mirroring works alike for 8, 4, 2 and 1 bit depths.
// - Fields leave lowest-numbered first, toward highest, in either setting.
// - 12, 16 and 24-bit colour formats work in both endian settings.
// - In 16-bit modes first word comes from inputs 0 to 15, mirrored if big.
`timescale 1ns/1ps
`default_nettype none
module pbeu_unpacker (
    input wire logic clk,
    input wire logic srst,
    input wire logic endianSel,
    input wire pbeu_pkg::pbeu_depth_t depth,
    input wire pbeu_pkg::pbeu_word_t wordIn,
    output logic wordReady,
    input wire logic pixReady,
    output pbeu_pkg::pbeu_pix_t pixOut
);
    import pbeu_pkg::*;

    function automatic logic [PBEU_CNT_W-1:0] fieldWidth(input pbeu_depth_t d);
        unique case (d)
            PBEU_D1: fieldWidth = 6'h01;
            PBEU_D2: fieldWidth = 6'h02;
            PBEU_D4: fieldWidth = 6'h04;
            PBEU_D8: fieldWidth = 6'h08;
            PBEU_D12: fieldWidth = 6'h0c;
            PBEU_D16: fieldWidth = 6'h10;
            PBEU_D24: fieldWidth = 6'h18;
            default: fieldWidth = 6'h08;
        endcase
    endfunction

    // 24-bit words carry one pixel and 12-bit words two, in the low 24 bits; others fill the word with whole fields
    function automatic logic [PBEU_CNT_W-1:0] fieldCount(input pbeu_depth_t d);
        unique case (d)
            PBEU_D1: fieldCount = 6'h20;
            PBEU_D2: fieldCount = 6'h10;
            PBEU_D4: fieldCount = 6'h08;
            PBEU_D8: fieldCount = 6'h04;
            PBEU_D12: fieldCount = 6'h02;
            PBEU_D16: fieldCount = 6'h02;
            PBEU_D24: fieldCount = 6'h01;
            default: fieldCount = 6'h04;
        endcase
    endfunction

    typedef enum logic [0:0] {
        PBEU_IDLE = 1'b0,
        PBEU_SHIFT = 1'b1
    } pbeu_state_t;

    typedef struct packed {
        pbeu_state_t state;
        logic [PBEU_BUS_W-1:0] word;
        logic big;
        logic [PBEU_CNT_W-1:0] width;
        logic [PBEU_CNT_W-1:0] remain;
        pbeu_pix_t pix;
    } pbeu_regs_t;

    pbeu_regs_t state_r;
    pbeu_regs_t state_nxt;
    logic [PBEU_FLD_W-1:0] rawField;
    logic [PBEU_FLD_W-1:0] mirField;
    logic outFree;
    logic lastField;

    pbeu_field_mirror u_mirror (
        .inField(rawField),
        .width(state_r.width),
        .outField(mirField)
    );

    always_comb begin
        rawField = '0;
        for (int i = 0; i < PBEU_FLD_W; i++) begin
            if (i < int'(state_r.width)) begin
                rawField[i] = state_r.word[i];
            end
        end
    end

    assign outFree = !state_r.pix.valid || pixReady;
    assign lastField = (state_r.remain == 6'h01);
    // New word once the last field of the previous one is loaded into pixOut
    assign wordReady = (state_r.state == PBEU_IDLE);

    always_comb begin
        state_nxt = state_r;
        if (state_r.pix.valid && pixReady) begin
            state_nxt.pix.valid = 1'b0;
            state_nxt.pix.last = 1'b0;
        end
        unique case (state_r.state)
            PBEU_IDLE: begin
                if (wordIn.valid) begin
                    state_nxt.word = wordIn.data;
                    state_nxt.big = endianSel;
                    state_nxt.width = fieldWidth(depth);
                    state_nxt.remain = fieldCount(depth);
                    state_nxt.state = PBEU_SHIFT;
                end
            end
            PBEU_SHIFT: begin
                if (outFree) begin
                    // Lowest field first; 16-bit first word from inputs 0 to 15
                    state_nxt.pix.field = state_r.big ? mirField : rawField;
                    state_nxt.pix.valid = 1'b1;
                    state_nxt.pix.last = lastField;
                    state_nxt.word = state_r.word >> state_r.width;
                    state_nxt.remain = state_r.remain - 6'h01;
                    if (lastField) begin
                        state_nxt.state = PBEU_IDLE;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            state_r <= '0;
            state_r.state <= PBEU_IDLE;
            state_r.big <= pbeu_endian_rst;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign pixOut = state_r.pix;
endmodule
`default_nettype wire

// File: pbeu_unpacker_asserts.sv
// Port checker for pbeu_unpacker, bound from the test top.
// Assumes first field leaves two edges after the word is taken.
`timescale 1ns/1ps
`default_nettype none
module pbeu_unpacker_asserts (
    input wire logic clk,
    input wire logic srst,
    input wire logic endianSel,
    input wire pbeu_pkg::pbeu_depth_t depth,
    input wire pbeu_pkg::pbeu_word_t wordIn,
    input wire logic wordReady,
    input wire logic pixReady,
    input wire pbeu_pkg::pbeu_pix_t pixOut
);
    import pbeu_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    wire tk = wordIn.valid && wordReady;
    wire [31:0] f = pixOut.field;
    a_reset_idle: assert property ($fell(srst) |-> wordReady && !pixOut.valid) else $error("bad");
    a_take_reply: assert property (tk |-> ##2 pixOut.valid) else $error("no field after word taken");
    a_stall_hold: assert property (pixOut.valid && !pixReady |=> $stable(pixOut)) else $error("bad");
    a_word_whole: assert property (pixOut.valid && !pixOut.last |-> !wordReady) else $error("bad");
    a_true_little: assert property (tk && depth == PBEU_D24 && !endianSel |-> ##2
        f == {8'h00, $past(wordIn.data[23:0], 2)}) else $error("24-bit field wrong");
    a_word_mirror: assert property (tk && depth == PBEU_D16 && endianSel |-> ##2
        {f[0], f[15]} == {$past(wordIn.data[15], 2), $past(wordIn.data[0], 2)}) else $error("16-bit mirror wrong");
    a_byte_mirror: assert property (tk && depth == PBEU_D8 && endianSel |-> ##2
        {f[0], f[7]} == {$past(wordIn.data[7], 2), $past(wordIn.data[0], 2)}) else $error("8-bit mirror wrong");
endmodule
`default_nettype wire

// File: pbeu_vram_model.sv
// Video RAM word source; holds a word until taken, then scrambles the bus.
// Assumes the test top pulses memWord.valid for one clock per word.
`timescale 1ns/1ps
`default_nettype none
module pbeu_vram_model (
    input wire logic clk,
    input wire logic reversed,
    input wire pbeu_pkg::pbeu_word_t memWord,
    input wire logic wordReady,
    output pbeu_pkg::pbeu_word_t wordOut
);
    logic [31:0] wired;
    // Big-endian board: top data line lands on the lowest pixel input
    always_comb begin
        for (int i = 0; i < 32; i++) begin
            wired[i] = memWord.data[31 - i];
        end
    end
    always @(posedge clk)
        if (memWord.valid) wordOut <= {reversed ? wired : memWord.data, 1'h1};
        else if (wordReady) wordOut <= {~wordOut.data, 1'h0};
endmodule
`default_nettype wire

// File: pbeu_unpacker_test.sv
// Test top: word source model, unpacker, bound checker; 100 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module pbeu_unpacker_test;
    import pbeu_pkg::*;
    logic clk = 1'h0, srst = 1'h1, endianSel = 1'h0, pixReady = 1'h1, wordReady;
    pbeu_depth_t depth = PBEU_D1;
    pbeu_word_t wordIn, memWord = '0;
    pbeu_pix_t pixOut;
    int error_cnt = 0, comparisons = 0, w[7] = '{1, 2, 4, 8, 12, 16, 24};
    pbeu_unpacker i_dut(.clk, .srst, .endianSel, .depth, .wordIn, .wordReady, .pixReady, .pixOut);
    pbeu_vram_model i_src(.clk, .reversed(endianSel), .memWord, .wordReady, .wordOut(wordIn));
    initial forever #5 clk = ~clk;
    task automatic chk(input logic [31:0] got, exp);
        comparisons++;
        error_cnt += int'(got !== exp);
        if (got !== exp) $display("mismatch %0t got %h want %h", $time, got, exp);
    endtask
    task automatic test_done();
        $display("errors %0d of %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // Big-endian fields come from the top of the memory word down
    task automatic run(input int d, st, input logic e, fl, input logic [31:0] m);
        // Code 7 is read as 8 bits per pixel
        int wd;
        wd = (d == 7) ? 8 : w[d];
        depth = pbeu_depth_t'(d);
        endianSel = e;
        memWord = {m, 1'h1};
        @(negedge clk);
        memWord.valid = 1'h0;
        pixReady = st == 0;
        for (int k = 0; k < 32 / wd; k++) begin
            for (int t = 0; t < 20 && pixOut.valid !== 1'h1; t++) @(negedge clk);
            chk({31'h0, pixOut.valid}, 32'h1);
            if (pixOut.valid !== 1'h1) test_done();
            repeat (st) @(negedge clk);
            chk(pixOut.field, m >> (e ? 32 - (k + 1) * wd : k * wd) & (32'h1 << wd) - 32'h1);
            chk({31'h0, pixOut.last}, {31'h0, k == 32 / wd - 1});
            endianSel = e ^ fl;
            pixReady = 1'h1;
            @(negedge clk);
            pixReady = st == 0;
        end
    endtask
    initial begin
        repeat (3) @(negedge clk);
        srst = 1'h0;
        chk({30'h0, wordReady, pixOut.valid}, 32'h2);
        for (int i = 0; i < 15; i++) run(i % 7, i % 2, i > 6, i == 14, 32'h8e3c_5a17 * (i + 1));
        // Reset in mid-word drops the rest of the word
        depth = PBEU_D8;
        endianSel = 1'h1;
        memWord = {32'h1234_5678, 1'h1};
        @(negedge clk);
        memWord.valid = 1'h0;
        repeat (3) @(negedge clk);
        chk({31'h0, pixOut.valid}, 32'h1);
        srst = 1'h1;
        @(negedge clk);
        srst = 1'h0;
        chk({30'h0, wordReady, pixOut.valid}, 32'h2);
        run(7, 0, 1'h0, 1'h0, 32'h3c5a_96e1);
        test_done();
    end
endmodule
bind pbeu_unpacker pbeu_unpacker_asserts i_chk(.clk, .srst, .endianSel, .depth, .wordIn, .wordReady, .pixReady, .pixOut);
`default_nettype wire
